/* verilog/slice_storage_pkg.sv */
// constants and types shared by the slice storage element design
// Summary of operation
// - register loads direct data while clock enable high
// - synchronous reset high clears the register, in shift mode only
// - RAM write enable stores data at address
// - written bit shows on output after edge
// - RAM read is combinational from address
// - support 16x1 and 32x1 RAM depths
// - in 32x1 mode written data also reaches wide mux output
// - shift register holds thirty-two stages chained through both tables, shifts in
// - shift only when clock enable is high
// - shift updates lut, wide mux, cascade outputs
// - lut output shows addressed stage, asynchronously
// - cascade carries stage fifteen, sixteenth edge
package slice_storage_pkg;

    // ***********************************************************
    // register map (byte addresses)
    // ***********************************************************
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] EVENT_COUNT_OFFSET = 8'h08;
    localparam logic [7:0] LAST_ADDR_OFFSET = 8'h0c;
    localparam logic [7:0] CONTENTS_OFFSET = 8'h10;

    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int CFG_SYNC_RESET_BIT = 0;
    localparam int CFG_MODE_LSB = 1;
    localparam int CFG_MODE_MSB = 2;
    localparam int STAT_REG_OUT_BIT = 0;
    localparam int STAT_LUT_OUT_BIT = 1;
    localparam int STAT_WIDE_MUX_BIT = 2;
    localparam int STAT_CASCADE_BIT = 3;

    // ***********************************************************
    // mode field codes and reset values
    // ***********************************************************
    localparam logic [1:0] MODE_CODE_RAM16 = 2'h0;
    localparam logic [1:0] MODE_CODE_RAM32 = 2'h1;
    localparam logic [1:0] MODE_CODE_SHIFT = 2'h2;
    localparam logic RESET_SYNC_RESET_CFG = 1'b1;
    localparam logic [15:0] RESET_EVENT_COUNT = 16'h0000;
    localparam logic [4:0] RESET_LAST_ADDR = 5'h00;
    localparam logic [31:0] RESET_LUT_CONTENTS = 32'h0000_0000;

    // ***********************************************************
    // geometry
    // ***********************************************************
    localparam int LUT_DEPTH = 16;
    localparam int PAIR_DEPTH = 32;
    localparam int LAST_STAGE = 15;

    typedef enum logic [2:0] {
        MODE_RAM16 = 3'b001,
        MODE_RAM32 = 3'b010,
        MODE_SHIFT = 3'b100
    } lut_mode_e;

endpackage : slice_storage_pkg

/* verilog/lut_bus_if.sv */
// signals between the slice control logic and the look-up table storage
`timescale 1ns/1ns
interface lut_bus_if;
    logic write_en;
    logic shift_en;
    logic [4:0] addr;
    logic data_in;
    logic read_g;
    logic read_f;
    logic last_stage;
    logic [31:0] contents;

    modport ctrl (
        output write_en,
        output shift_en,
        output addr,
        output data_in,
        input read_g,
        input read_f,
        input last_stage,
        input contents
    );

    modport mem (
        input write_en,
        input shift_en,
        input addr,
        input data_in,
        output read_g,
        output read_f,
        output last_stage,
        output contents
    );
endinterface : lut_bus_if

/* verilog/lut_storage.sv */
// pair of 16-entry look-up tables used as RAM or as a chained shift register
`timescale 1ns/1ns
module lut_storage
    import slice_storage_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    lut_bus_if.mem bus
);

    typedef struct packed {
        logic [31:0] bits;
    } lut_state_s;

    lut_state_s state;
    lut_state_s next_state;
    logic [31:0] next_bits;

    // ***********************************************************
    // per entry next value: shift wins, else addressed write, else hold
    // ***********************************************************
    genvar g;
    generate
        for (g = 0; g < PAIR_DEPTH; g++) begin : g_entry
            logic shift_src;
            if (g == 0) begin : g_head
                assign shift_src = bus.data_in;
            end else begin : g_body
                assign shift_src = state.bits[g - 1];
            end
            assign next_bits[g] = bus.shift_en ? shift_src :
                (bus.write_en && bus.addr == 5'(g)) ? bus.data_in :
                state.bits[g];
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.bits = next_bits;
        if (i_rst) begin
            next_state.bits = RESET_LUT_CONTENTS;
        end
    end

    always_ff @(posedge i_core_clk) begin
        state <= next_state;
    end

    // ***********************************************************
    // asynchronous read ports
    // ***********************************************************
    assign bus.read_g = state.bits[bus.addr[3:0]];
    assign bus.read_f = state.bits[{1'b1, bus.addr[3:0]}];
    assign bus.last_stage = state.bits[LAST_STAGE];
    assign bus.contents = state.bits;

endmodule : lut_storage

/* verilog/slice_storage_elements.sv */
// slice storage elements: register, distributed RAM and shift register, APB configured
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module slice_storage_elements
    import slice_storage_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // slice register
    input wire logic i_direct_data_in,
    input wire logic i_clk_enable,
    input wire logic i_set_reset_in,
    output logic o_registered_out,
    // look-up table
    input wire logic [4:0] i_lut_addr,
    input wire logic [1:0] i_bypass_inputs,
    output logic o_lut_out,
    output logic o_wide_mux_out,
    output logic o_cascade_outputs
);

    // ***********************************************************
    // state
    // ***********************************************************
    typedef struct packed {
        logic registered_out;
        lut_mode_e mode;
        logic ff_sync_reset;
        logic [31:0] prdata;
        logic [15:0] event_count;
        logic [4:0] last_addr;
    } slice_state_s;

    slice_state_s state;
    slice_state_s next_state;

    lut_bus_if lut_bus ();

    logic lut_data_in;
    logic ram_mode;
    logic lut_event;
    logic apb_setup;
    logic apb_access;
    logic addr_mapped;
    logic addr_writable;
    logic mode_code_valid;
    logic [1:0] wr_mode_code;
    logic [1:0] rd_mode_code;
    logic [31:0] read_value;
    logic [31:0] status_word;
    logic wide_mux_value;
    logic lut_value;

    // ***********************************************************
    // look-up table control
    // ***********************************************************
    assign lut_data_in = i_bypass_inputs[0];
    assign ram_mode = (state.mode != MODE_SHIFT);

    always_comb begin
        lut_bus.write_en = 1'b0;
        lut_bus.shift_en = 1'b0;
        lut_bus.addr = i_lut_addr;
        lut_bus.data_in = lut_data_in;
        case (state.mode)
            MODE_RAM16: begin
                // single table: upper address bit is ignored
                lut_bus.write_en = i_set_reset_in;
                lut_bus.addr = {1'b0, i_lut_addr[3:0]};
            end
            MODE_RAM32: begin
                lut_bus.write_en = i_set_reset_in;
                lut_bus.addr = i_lut_addr;
            end
            MODE_SHIFT: begin
                lut_bus.shift_en = i_clk_enable;
            end
            default: begin
                lut_bus.write_en = 1'b0;
            end
        endcase
    end

    lut_storage u_lut_storage (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .bus(lut_bus.mem)
    );

    assign lut_event = lut_bus.write_en | lut_bus.shift_en;

    // ***********************************************************
    // slice outputs
    // ***********************************************************
    // two tables joined by the wide mux, upper address bit selects
    assign wide_mux_value = i_lut_addr[4] ? lut_bus.read_f : lut_bus.read_g;

    always_comb begin
        lut_value = lut_bus.read_g;
        if (state.mode == MODE_RAM32) begin
            lut_value = wide_mux_value;
        end
    end

    // reads follow the stored bits combinationally, so a write at an
    // edge shows here right after it if the address is held
    assign o_lut_out = lut_value;
    assign o_wide_mux_out = wide_mux_value;
    assign o_cascade_outputs = lut_bus.last_stage;
    assign o_registered_out = state.registered_out;

    // ***********************************************************
    // apb decode
    // ***********************************************************
    assign apb_setup = i_psel & ~i_penable;
    assign apb_access = i_psel & i_penable;
    assign wr_mode_code = i_pwdata[CFG_MODE_MSB:CFG_MODE_LSB];

    always_comb begin
        mode_code_valid = 1'b0;
        if (wr_mode_code == MODE_CODE_RAM16) begin
            mode_code_valid = 1'b1;
        end else if (wr_mode_code == MODE_CODE_RAM32) begin
            mode_code_valid = 1'b1;
        end else if (wr_mode_code == MODE_CODE_SHIFT) begin
            mode_code_valid = 1'b1;
        end
    end

    always_comb begin
        addr_mapped = 1'b0;
        addr_writable = 1'b0;
        if (i_paddr == CONFIG_OFFSET) begin
            addr_mapped = 1'b1;
            addr_writable = mode_code_valid;
        end else if (i_paddr == STATUS_OFFSET) begin
            addr_mapped = 1'b1;
        end else if (i_paddr == EVENT_COUNT_OFFSET) begin
            addr_mapped = 1'b1;
            addr_writable = 1'b1;
        end else if (i_paddr == LAST_ADDR_OFFSET) begin
            addr_mapped = 1'b1;
        end else if (i_paddr == CONTENTS_OFFSET) begin
            addr_mapped = 1'b1;
        end
    end

    always_comb begin
        rd_mode_code = MODE_CODE_RAM16;
        case (state.mode)
            MODE_RAM16: rd_mode_code = MODE_CODE_RAM16;
            MODE_RAM32: rd_mode_code = MODE_CODE_RAM32;
            MODE_SHIFT: rd_mode_code = MODE_CODE_SHIFT;
            default: rd_mode_code = MODE_CODE_RAM16;
        endcase
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_REG_OUT_BIT] = state.registered_out;
        status_word[STAT_LUT_OUT_BIT] = lut_value;
        status_word[STAT_WIDE_MUX_BIT] = wide_mux_value;
        status_word[STAT_CASCADE_BIT] = lut_bus.last_stage;
    end

    always_comb begin
        read_value = 32'h0000_0000;
        if (i_paddr == CONFIG_OFFSET) begin
            read_value[CFG_SYNC_RESET_BIT] = state.ff_sync_reset;
            read_value[CFG_MODE_MSB:CFG_MODE_LSB] = rd_mode_code;
        end else if (i_paddr == STATUS_OFFSET) begin
            read_value = status_word;
        end else if (i_paddr == EVENT_COUNT_OFFSET) begin
            read_value = {16'h0000, state.event_count};
        end else if (i_paddr == LAST_ADDR_OFFSET) begin
            read_value = {27'h0, state.last_addr};
        end else if (i_paddr == CONTENTS_OFFSET) begin
            read_value = lut_bus.contents;
        end
    end

    // every access completes in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = apb_access & (~addr_mapped | (i_pwrite & ~addr_writable));
    assign o_prdata = state.prdata;

    // ***********************************************************
    // next state
    // ***********************************************************
    always_comb begin
        next_state = state;

        // slice register: reset beats clock enable; in RAM modes the
        // set/reset pin is the write enable and leaves the register alone
        if (state.ff_sync_reset && !ram_mode && i_set_reset_in) begin
            next_state.registered_out = 1'b0;
        end else if (i_clk_enable) begin
            next_state.registered_out = i_direct_data_in;
        end

        // activity bookkeeping
        if (lut_event) begin
            next_state.last_addr = lut_bus.addr;
        end

        // read data captured in the setup cycle, stable through access
        if (apb_setup && !i_pwrite) begin
            next_state.prdata = read_value;
        end

        // software write to the counter clears it; a same-cycle event then counts as 1
        if (apb_access && i_pwrite && !o_pslverr) begin
            if (i_paddr == CONFIG_OFFSET) begin
                next_state.ff_sync_reset = i_pwdata[CFG_SYNC_RESET_BIT];
                case (wr_mode_code)
                    MODE_CODE_RAM32: next_state.mode = MODE_RAM32;
                    MODE_CODE_SHIFT: next_state.mode = MODE_SHIFT;
                    default: next_state.mode = MODE_RAM16;
                endcase
            end else if (i_paddr == EVENT_COUNT_OFFSET) begin
                next_state.event_count = RESET_EVENT_COUNT;
            end
        end
        if (lut_event) begin
            if (apb_access && i_pwrite && !o_pslverr && i_paddr == EVENT_COUNT_OFFSET) begin
                next_state.event_count = 16'h0001;
            end else begin
                next_state.event_count = state.event_count + 16'h0001;
            end
        end

        if (i_rst) begin
            next_state.registered_out = 1'b0;
            next_state.mode = MODE_RAM16;
            next_state.ff_sync_reset = RESET_SYNC_RESET_CFG;
            next_state.prdata = 32'h0000_0000;
            next_state.event_count = RESET_EVENT_COUNT;
            next_state.last_addr = RESET_LAST_ADDR;
        end
    end

    always_ff @(posedge i_core_clk) begin
        state <= next_state;
    end

endmodule : slice_storage_elements

/* tb/slice_storage_properties.sv */
// port-level checks for the slice storage elements
`timescale 1ns/1ns
module slice_storage_checker
    import slice_storage_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_direct_data_in,
    input wire logic i_clk_enable,
    input wire logic i_set_reset_in,
    input wire logic o_registered_out,
    input wire logic [4:0] i_lut_addr,
    input wire logic [1:0] i_bypass_inputs,
    input wire logic o_lut_out,
    input wire logic o_wide_mux_out,
    input wire logic o_cascade_outputs
);
    // ***********************************************
    // mode tracking from accepted config writes
    // ***********************************************
    logic [1:0] mode;
    logic srst;
    logic cfg_wr;
    logic ram;
    logic shreg;
    assign cfg_wr = i_psel && i_penable && i_pwrite && i_paddr == CONFIG_OFFSET && !o_pslverr;
    // the edge of a mode change is skipped: stored bits are read anew
    assign ram = !cfg_wr && mode != MODE_CODE_SHIFT;
    assign shreg = !cfg_wr && mode == MODE_CODE_SHIFT;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode <= MODE_CODE_RAM16;
            srst <= RESET_SYNC_RESET_CFG;
        end else if (cfg_wr) begin
            mode <= i_pwdata[CFG_MODE_MSB:CFG_MODE_LSB];
            srst <= i_pwdata[CFG_SYNC_RESET_BIT];
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_load; ram && i_clk_enable |=> o_registered_out == $past(i_direct_data_in);
    endproperty
    a_load: assert property (p_load) else $error("register load wrong");
    property p_hold; ram && !i_clk_enable |=> $stable(o_registered_out);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed");
    property p_clear; shreg && srst && i_set_reset_in |=> !o_registered_out;
    endproperty
    a_clear: assert property (p_clear) else $error("register not cleared");
    property p_write; ram && i_set_reset_in ##1 $stable(i_lut_addr)
        |-> o_lut_out == $past(i_bypass_inputs[0]);
    endproperty
    a_write: assert property (p_write) else $error("ram write not seen");
    property p_nowrite; ram && !i_set_reset_in ##1 $stable(i_lut_addr) |-> $stable(o_lut_out);
    endproperty
    a_nowrite: assert property (p_nowrite) else $error("ram changed");
    property p_mux; ram && mode == MODE_CODE_RAM32 && i_set_reset_in ##1 $stable(i_lut_addr)
        |-> o_wide_mux_out == $past(i_bypass_inputs[0]);
    endproperty
    a_mux: assert property (p_mux) else $error("wide mux wrong");
    property p_shift; shreg && i_clk_enable && i_lut_addr[3:0] == 4'h0 ##1 $stable(i_lut_addr)
        |-> o_lut_out == $past(i_bypass_inputs[0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift in wrong");
    property p_shift_hold; shreg && !i_clk_enable ##1 $stable(i_lut_addr)
        |-> $stable(o_lut_out) && $stable(o_cascade_outputs);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("stages moved");
    property p_casc; shreg && i_clk_enable && i_lut_addr == 5'h0e
        |=> o_cascade_outputs == $past(o_lut_out);
    endproperty
    a_casc: assert property (p_casc) else $error("cascade wrong");
    property p_err; i_psel && i_penable && i_paddr == 8'h14 |-> o_pslverr && o_pready;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access accepted");
    c_ram32: cover property (ram && mode == MODE_CODE_RAM32 && i_set_reset_in);
    c_shift: cover property (shreg && i_clk_enable);
    c_clear: cover property (shreg && srst && i_set_reset_in);
endmodule : slice_storage_checker
bind slice_storage_elements slice_storage_checker u_chk (.*);

/* tb/fabric_model.sv */
// user fabric logic that drives the slice data, address and enables
`timescale 1ns/1ns
module fabric_model (
    input wire logic i_core_clk,
    output logic o_clk_enable,
    output logic o_direct_data_in,
    output logic o_set_reset_in,
    output logic [4:0] o_lut_addr,
    output logic [1:0] o_bypass_inputs
);
    initial begin
        o_clk_enable = 1'b0;
        o_direct_data_in = 1'b0;
        o_set_reset_in = 1'b0;
        o_lut_addr = 5'h00;
        o_bypass_inputs = 2'h0;
    end
    // one enabled edge, then idle with data no longer held
    task automatic op(input logic ce, input logic d, input logic we, input logic [4:0] a,
        input logic b);
        @(posedge i_core_clk);
        o_clk_enable <= ce;
        o_direct_data_in <= d;
        o_set_reset_in <= we;
        o_lut_addr <= a;
        o_bypass_inputs <= {~b, b};
        @(posedge i_core_clk);
        o_clk_enable <= 1'b0;
        o_set_reset_in <= 1'b0;
        o_bypass_inputs <= ~o_bypass_inputs;
    endtask : op
    task automatic addr(input logic [4:0] a);
        @(posedge i_core_clk);
        o_lut_addr <= a;
    endtask : addr
endmodule : fabric_model

/* tb/testbench.sv */
// self-checking bench for the slice storage elements
`timescale 1ns/1ns
module testbench;
    import slice_storage_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_registered_out, o_lut_out, o_wide_mux_out, o_cascade_outputs;
    logic i_direct_data_in, i_clk_enable, i_set_reset_in;
    logic [4:0] i_lut_addr;
    logic [1:0] i_bypass_inputs;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int cmp_count = 0;
    // rows: clock enable, data, set/reset, expected output
    logic [3:0] rows [5] = '{4'h8, 4'h4, 4'hd, 4'hf, 4'h1};
    logic [39:0] rst_tab [4] = '{40'h00_0000_0001, 40'h08_0000_0000, 40'h0c_0000_0000,
        40'h10_0000_0000};
    always #10 i_core_clk = ~i_core_clk;
    slice_storage_elements DUT (.*);
    fabric_model fab (.i_core_clk(i_core_clk), .o_clk_enable(i_clk_enable),
        .o_direct_data_in(i_direct_data_in), .o_set_reset_in(i_set_reset_in),
        .o_lut_addr(i_lut_addr), .o_bypass_inputs(i_bypass_inputs));
    // ***********************************************
    // shared tasks
    // ***********************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= wd;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        foreach (rows[k]) begin
            fab.op(rows[k][3], rows[k][2], rows[k][1], 5'h00, rows[k][2]);
            #1;
            chk(o_registered_out, rows[k][0]);
        end
        fab.op(1'b0, 1'b0, 1'b1, 5'h02, 1'b1);
        #1;
        chk(o_lut_out, 1'b1);
        fab.addr(5'h01);
        #1;
        chk(o_lut_out, 1'b0);
        fab.addr(5'h00);
        #1;
        chk(o_lut_out, 1'b1);
        apb(1'b1, CONFIG_OFFSET, 32'h3);
        fab.op(1'b0, 1'b0, 1'b1, 5'h13, 1'b1);
        #1;
        chk(o_lut_out, 1'b1);
        chk(o_wide_mux_out, 1'b1);
        apb(1'b0, CONTENTS_OFFSET, 32'h0);
        chk(rd, 32'h0008_0005);
        apb(1'b0, 8'h14, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, CONFIG_OFFSET, 32'h7);
        chk(er, 1'b1);
        apb(1'b0, CONFIG_OFFSET, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, CONFIG_OFFSET, 32'h5);
        apb(1'b1, EVENT_COUNT_OFFSET, 32'h0);
        for (int k = 0; k < 16; k++) begin
            fab.op(1'b1, 1'b0, 1'b0, (k == 14) ? 5'h0e : 5'h00, k != 0);
            #1;
            if (k != 14) chk(o_lut_out, k != 0);
            if (k >= 14) chk(o_cascade_outputs, k == 14);
        end
        apb(1'b0, CONTENTS_OFFSET, 32'h0);
        chk(rd, 32'h0005_7fff);
        apb(1'b0, EVENT_COUNT_OFFSET, 32'h0);
        chk(rd, 32'h10);
        fab.addr(5'h0f);
        #1;
        chk(o_lut_out, 1'b0);
        fab.addr(5'h01);
        #1;
        chk(o_lut_out, 1'b1);
        fab.op(1'b1, 1'b1, 1'b0, 5'h0f, 1'b1);
        #1;
        chk(o_registered_out, 1'b1);
        fab.op(1'b1, 1'b1, 1'b1, 5'h0f, 1'b1);
        #1;
        chk(o_registered_out, 1'b0);
        fab.op(1'b1, 1'b1, 1'b0, 5'h0f, 1'b1);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'hf);
        apb(1'b0, LAST_ADDR_OFFSET, 32'h0);
        chk(rd, 32'hf);
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        chk(o_registered_out, 1'b0);
        foreach (rst_tab[k]) begin
            apb(1'b0, rst_tab[k][39:32], 32'h0);
            chk(rd, rst_tab[k][31:0]);
        end
        final_report();
    end
endmodule : testbench
